// File: sad_pkg.sv
// Package for the stereo audio converter datapath: constants, types and coding helpers.
// Assumes a single 125 MHz clock domain and no software-visible registers.
// Functional notes
// - Two independent channels, left and right, each with its own sample stream.
// - Each channel queues up to four samples, consumed in order, one per period.
// - An empty queue at sample time makes the channel use the default sample.
// - Each channel is up-sampled by 256, inserting points between supplied samples.
// - Interpolation filtering pushes quantisation noise above the 20 kHz pass band.
// - Interpolated samples feed a second-order delta-sigma modulator giving one bit.
// - A 128-tap reconstruction filter turns the bit stream into a differential output.
// - A user sample clock sets the rate, at most 100 thousand samples per second.
// - Samples are 16 bits, written by processor or DMA transfers.
// - Format select chooses unsigned or two's-complement input coding.
package sad_pkg;
  localparam int SAMPLE_W = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_W = 2;
  localparam int CNT_W = 3;
  localparam int OSR = 256;
  localparam int OSR_W = 8;
  localparam int TAPS = 128;
  localparam int TAP_W = 7;
  localparam int ACC_W = 24;
  localparam int REF_HZ = 125000000;
  localparam int MAX_RATE_SPS = 100000;
  // Shortest legal sample period in reference cycles (rounded up).
  localparam int MIN_PERIOD_CYC = (REF_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS;
  // Reference cycles per interpolation step, so that 256 steps fit in the shortest period.
  localparam int STEP_DIV = MIN_PERIOD_CYC / OSR;
  // Modulator integrator limit, and the filter count at which the output calls a majority.
  localparam int ACC_MAX = (1 << (ACC_W - 1)) - 1;
  localparam int TAP_HALF = TAPS / 2;
  localparam int PASS_BAND_HZ = 20000;
  localparam logic [SAMPLE_W-1:0] MIDPOINT_CODE = 16'h8000;
  localparam logic [SAMPLE_W-1:0] DEFAULT_RST = 16'h0000;
  localparam logic FORMAT_UNSIGNED = 1'b0;
  localparam logic FORMAT_SIGNED = 1'b1;

  typedef enum logic {SAD_LEFT, SAD_RIGHT} sad_chan_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] data;
    logic valid;
  } sad_sample_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } sad_diff_t;

  // Converts either input coding to a signed value around zero.
  function automatic logic signed [SAMPLE_W-1:0] sad_to_signed(input logic [SAMPLE_W-1:0] code,
                                                                input logic fmt);
    sad_to_signed = (fmt == FORMAT_SIGNED) ? code : (code ^ MIDPOINT_CODE);
  endfunction : sad_to_signed
endpackage : sad_pkg

// File: sad_top.sv
// Stereo audio converter datapath: sample queues, default substitution, 256x interpolation,
// second-order delta-sigma modulation and a 128-tap bit-stream reconstruction filter.
// Assumes writers and sample ticks are synchronous to ref_clk; the sample tick must not
// come faster than the 100 ksps limit, and software preloads a safe default sample.
`timescale 1ns/1ps
module sad_top (
  input wire logic ref_clk, // 125 MHz clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic clk_en, // Freezes all state while low
  input wire logic sample_tick, // User sample clock, one pulse per sample period
  input wire logic sample_format_select, // 1 = two's complement, 0 = unsigned
  input wire logic [sad_pkg::SAMPLE_W-1:0] default_sample_register, // Sample used on empty queue
  input wire sad_pkg::sad_sample_t wr_left, // Left channel write from CPU or DMA
  input wire sad_pkg::sad_sample_t wr_right, // Right channel write from CPU or DMA
  output sad_pkg::sad_diff_t out_left, // Left differential output bits
  output sad_pkg::sad_diff_t out_right, // Right differential output bits
  output logic [1:0] fifo_ready, // Queue not full, per channel
  output logic [1:0] used_default // Default substituted at last tick, per channel
);
  import sad_pkg::*;

  sad_sample_t wr [2];
  assign wr[0] = wr_left;
  assign wr[1] = wr_right;

  // ****************************************
  // Up-sample step timing
  // ****************************************
  // Up-sample phase shared by both channels; a sub-step advances on a fixed divider so the
  // 256 interpolated points of a period fit inside the shortest legal sample period.
  localparam logic [2:0] STEP_LAST = 3'(STEP_DIV - 1);
  logic [2:0] div_reg;
  logic step;
  logic [OSR_W:0] phase_reg;
  logic ramp;
  assign step = (div_reg == STEP_LAST);
  assign ramp = step && !phase_reg[OSR_W];
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      div_reg <= 3'h0;
    else if (clk_en)
      div_reg <= (step || sample_tick) ? 3'h0 : div_reg + 3'h1;
  end

  // A slow sample clock leaves more steps in a period than there are interpolated points;
  // the ramp stops after the last point so the value rests on the new sample, not past it.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      phase_reg <= '0;
    else if (clk_en)
    begin
      if (sample_tick)
        phase_reg <= '0;
      else if (ramp)
        phase_reg <= phase_reg + (OSR_W+1)'(1);
    end
  end

  // Clamps a wide modulator sum into the accumulator range. A second-order loop driven at full
  // scale drifts without bound, and a wrapped integrator would flip the output bit.
  function automatic logic signed [ACC_W-1:0] acc_clamp(input logic signed [ACC_W+1:0] v);
    if (v > (ACC_W+2)'(ACC_MAX))
      acc_clamp = ACC_W'(ACC_MAX);
    else if (v < -(ACC_W+2)'(ACC_MAX))
      acc_clamp = -ACC_W'(ACC_MAX);
    else
      acc_clamp = ACC_W'(v);
  endfunction : acc_clamp

  // ****************************************
  // Per-channel pipeline
  // ****************************************
  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_chan
      logic [SAMPLE_W-1:0] mem [FIFO_DEPTH];
      logic [PTR_W-1:0] wp_reg, rp_reg;
      logic [CNT_W-1:0] cnt_reg;
      logic push, pop;
      logic signed [SAMPLE_W-1:0] cur_reg, prev_reg, sel;
      logic signed [SAMPLE_W+OSR_W:0] interp_reg, delta;
      logic signed [ACC_W-1:0] i1_reg, i2_reg, fb;
      logic bit_reg;
      logic [TAPS-1:0] taps_reg;
      logic [TAP_W:0] ones_reg;
      sad_diff_t d_reg;
      logic dflt_reg;
      logic rdy_reg;

      assign push = wr[c].valid && (cnt_reg != CNT_W'(FIFO_DEPTH));
      assign pop = sample_tick && (cnt_reg != 3'h0);
      assign sel = (cnt_reg != 3'h0) ? sad_to_signed(mem[rp_reg], sample_format_select)
                   : sad_to_signed(default_sample_register, sample_format_select);

      // ****************************************
      // Sample queue
      // ****************************************
      always_ff @(posedge ref_clk)
      begin
        if (clk_en && push)
          mem[wp_reg] <= wr[c].data;
      end

      // Queue pointers; a write landing on an empty queue is seen at the next tick.
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          wp_reg <= 2'h0;
          rp_reg <= 2'h0;
          cnt_reg <= 3'h0;
        end
        else if (clk_en)
        begin
          if (push)
            wp_reg <= wp_reg + 2'h1;
          if (pop)
            rp_reg <= rp_reg + 2'h1;
          cnt_reg <= cnt_reg + CNT_W'(push) - CNT_W'(pop);
        end
      end

      // ****************************************
      // Sample capture
      // ****************************************
      // Sample capture at each tick, with the default repeating while the queue is empty.
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          cur_reg <= '0;
          prev_reg <= '0;
          dflt_reg <= 1'b0;
        end
        else if (clk_en && sample_tick)
        begin
          prev_reg <= cur_reg;
          cur_reg <= sel;
          dflt_reg <= (cnt_reg == 3'h0);
        end
      end

      // ****************************************
      // Interpolator
      // ****************************************
      // Linear interpolation: each step adds 1/256 of the difference, scaled by 256.
      // Linear hold-off plus the modulator's noise shaping keeps noise above the pass band.
      assign delta = (SAMPLE_W + OSR_W + 1)'(cur_reg) - (SAMPLE_W + OSR_W + 1)'(prev_reg);
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          interp_reg <= '0;
        else if (clk_en)
        begin
          if (sample_tick)
            interp_reg <= (SAMPLE_W + OSR_W + 1)'(cur_reg) <<< OSR_W;
          else if (ramp)
            interp_reg <= interp_reg + delta;
        end
      end

      // ****************************************
      // Modulator
      // ****************************************
      // Second-order error-feedback modulator on the top 16 bits of the interpolated value.
      assign fb = bit_reg ? ACC_W'(32767) : -ACC_W'(32768);
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          i1_reg <= '0;
          i2_reg <= '0;
          bit_reg <= 1'b0;
        end
        else if (clk_en && step)
        begin
          i1_reg <= acc_clamp((ACC_W+2)'(i1_reg) + (ACC_W+2)'(interp_reg >>> OSR_W) - (ACC_W+2)'(fb));
          i2_reg <= acc_clamp((ACC_W+2)'(i2_reg) + (ACC_W+2)'(i1_reg) - (ACC_W+2)'(fb));
          bit_reg <= ~i2_reg[ACC_W-1];
        end
      end

      // ****************************************
      // Reconstruction filter
      // ****************************************
      // Boxcar FIR over the last 128 bits; a running count avoids a 128-input adder.
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          taps_reg <= '0;
          ones_reg <= '0;
        end
        else if (clk_en && step)
        begin
          taps_reg <= {taps_reg[TAPS-2:0], bit_reg};
          ones_reg <= ones_reg + (TAP_W+1)'(bit_reg) - (TAP_W+1)'(taps_reg[TAPS-1]);
        end
      end

      // ****************************************
      // Outputs
      // ****************************************
      // Differential output: majority of the tap window drives pos, its complement neg.
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          d_reg <= '{pos: 1'b0, neg: 1'b1};
        else if (clk_en)
          d_reg <= '{pos: (ones_reg >= (TAP_W+1)'(TAP_HALF)), neg: (ones_reg < (TAP_W+1)'(TAP_HALF))};
      end

      // Room flag from the count this edge leaves, so a writer never sees a stale free slot.
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
          rdy_reg <= 1'b0;
        else if (clk_en)
          rdy_reg <= (cnt_reg + CNT_W'(push) - CNT_W'(pop)) != CNT_W'(FIFO_DEPTH);
      end
    end
  endgenerate

  // Each output comes straight from its channel's flip-flops.
  assign out_left = g_chan[0].d_reg;
  assign out_right = g_chan[1].d_reg;
  assign fifo_ready = {g_chan[1].rdy_reg, g_chan[0].rdy_reg};
  assign used_default = {g_chan[1].dflt_reg, g_chan[0].dflt_reg};
endmodule : sad_top

// File: sad_assertions.sv
// Port checker for the stereo converter datapath.
// Assumes the sad_top ports; bound after the module.
`timescale 1ns/1ps
module sad_checker
(
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic clk_en, // Enable
  input wire logic sample_tick, // Tick
  input wire logic sample_format_select, // Format
  input wire logic [sad_pkg::SAMPLE_W-1:0] default_sample_register, // Default
  input wire sad_pkg::sad_sample_t wr_left, // Left write
  input wire sad_pkg::sad_sample_t wr_right, // Right write
  input wire sad_pkg::sad_diff_t out_left, // Left out
  input wire sad_pkg::sad_diff_t out_right, // Right out
  input wire logic [1:0] fifo_ready, // Room
  input wire logic [1:0] used_default // Default taken
);
  import sad_pkg::*;
  // A write on the same edge as a pop from an empty queue is not counted as consumed.
  logic [2:0] lc_reg;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      lc_reg <= 3'h0;
    else if (clk_en)
      lc_reg <= lc_reg + 3'(wr_left.valid && lc_reg < 3'h4) - 3'(sample_tick && lc_reg != 3'h0);
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  diff_left_a: assert property (out_left.neg == !out_left.pos) else $error("left pair");
  diff_right_a: assert property (out_right.neg == !out_right.pos) else $error("right pair");
  freeze_hold_a: assert property (!clk_en |=> $stable(out_left) && $stable(out_right) && $stable(fifo_ready)
    && $stable(used_default)) else $error("no freeze");
  default_pick_a: assert property (sample_tick && clk_en |=> used_default[0] == ($past(lc_reg) == 3'h0))
    else $error("default pick");
  left_full_a: assert property (lc_reg == 3'h4 && !sample_tick |=> !fifo_ready[0]) else $error("full");
  left_room_a: assert property (lc_reg < 3'h3 |=> fifo_ready[0]) else $error("room");
  right_fall_a: assert property ($fell(fifo_ready[1]) |-> $past(wr_right.valid) || $past(wr_right.valid, 2))
    else $error("right fall");
  default_hold_a: assert property (!$past(sample_tick) |-> $stable(used_default)) else $error("hold");
endmodule : sad_checker
bind sad_top sad_checker u_chk (.ref_clk, .rst, .clk_en, .sample_tick, .sample_format_select,
  .default_sample_register, .wr_left, .wr_right, .out_left, .out_right, .fifo_ready, .used_default);

// File: sad_writer.sv
// Model of the processor or DMA writer of one sample queue.
// Assumes ready is the queue's room flag on ref_clk.
`timescale 1ns/1ps
module sad_writer
(
  input wire logic ref_clk, // Clock
  input wire logic ready, // Room
  output sad_pkg::sad_sample_t wr // Write
);
  import sad_pkg::*;
  initial wr = '{data: 16'h5a5a, valid: 1'b0};
  task automatic put(input logic [SAMPLE_W-1:0] d);
    do @(posedge ref_clk); while (ready !== 1'b1);
    #1 wr = '{data: d, valid: 1'b1};
    @(posedge ref_clk);
    // Idle data is inverted so a stale word cannot pass as new.
    #1 wr = '{data: ~d, valid: 1'b0};
  endtask : put
endmodule : sad_writer

// File: tb_top.sv
// Self-checking bench for the stereo converter datapath.
// Assumes sad_top, two writer models and the bound checker.
`timescale 1ns/1ps
module tb_top;
  import sad_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, sample_tick = 1'b0, sample_format_select = 1'b0;
  logic [SAMPLE_W-1:0] default_sample_register = MIDPOINT_CODE;
  sad_sample_t wr_left, wr_right;
  sad_diff_t out_left, out_right;
  logic [1:0] fifo_ready, used_default;
  int failures = 0, compares = 0, cycles = 0, ones;
  sad_top u_dut (.ref_clk, .rst, .clk_en, .sample_tick, .sample_format_select, .default_sample_register,
    .wr_left, .wr_right, .out_left, .out_right, .fifo_ready, .used_default);
  sad_writer u_wl (.ref_clk, .ready(fifo_ready[0]), .wr(wr_left));
  sad_writer u_wr (.ref_clk, .ready(fifo_ready[1]), .wr(wr_right));
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (++cycles == 60000)
    begin
      failures++;
      close_out();
    end
  end
  task automatic close_out();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick();
    @(posedge ref_clk);
    #1 sample_tick = 1'b1;
    @(posedge ref_clk);
    #1 sample_tick = 1'b0;
    repeat (1250) @(posedge ref_clk);
  endtask : tick
  task automatic t_empty();
    tick();
    chk(16'(used_default), 16'h3);
    tick();
    chk(16'(used_default), 16'h3);
  endtask : t_empty
  task automatic t_fill();
    fork
      for (int i = 0; i < 4; i++) u_wl.put(16'h1111 << i);
      u_wr.put(16'h4321);
    join
    repeat (2) @(posedge ref_clk);
    chk(16'(fifo_ready), 16'h2);
    #1 clk_en = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 clk_en = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      tick();
      chk(16'(used_default), i == 0 ? 16'h0 : (i < 4 ? 16'h2 : 16'h3));
      chk(16'(fifo_ready), 16'h3);
    end
  endtask : t_fill
  task automatic t_level();
    logic [16:0] tbl [4] = '{{1'b0, 16'hffff}, {1'b0, 16'h0000}, {1'b1, 16'h7fff}, {1'b1, 16'h8000}};
    for (int i = 0; i < 4; i++)
    begin
      #1 {sample_format_select, default_sample_register} = tbl[i];
      repeat (3) tick();
      ones = 0;
      repeat (512)
      begin
        @(posedge ref_clk);
        ones += out_left.pos + out_right.pos;
      end
      chk(16'(i[0] ? ones < 256 : ones > 768), 16'h1);
    end
  endtask : t_level
  task automatic t_right();
    for (int i = 0; i < 4; i++) u_wr.put(16'h8000 ^ (16'h0101 << i));
    repeat (2) @(posedge ref_clk);
    chk(16'(fifo_ready), 16'h1);
    for (int i = 0; i < 4; i++)
    begin
      tick();
      chk(16'(used_default), 16'h1);
      chk(16'(fifo_ready), 16'h3);
    end
    tick();
    chk(16'(used_default), 16'h3);
  endtask : t_right
  initial
  begin
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'b0;
    t_empty();
    t_fill();
    t_right();
    t_level();
    close_out();
  end
endmodule : tb_top
